// *** bench/sbgp_chk.sv ***
// Port-level checker for the six-bit port
`timescale 1ns/1ps
module sbgp_chk (
  input wire       clock,
  input wire       rstn,
  input wire [5:0] io_addr,
  input wire       io_read,
  input wire [7:0] io_rdata,
  input wire       ext_reset_enable,
  input wire       clock_pins_enable,
  input wire [5:0] pin_in,
  input wire [5:0] pin_out,
  input wire [5:0] pin_oe,
  input wire [5:0] pin_pullup,
  input wire       comparator_positive_input,
  input wire       comparator_negative_input
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Pin-five and pull-up rules hold every cycle; other pad controls, read data and taps follow their causes with fixed latency
  rd_idle_a: assert property (!io_read |=> io_rdata == 8'h00) else $error("rdata");
  od_low_a: assert property (pin_out[5] == 1'b0) else $error("pin5 high");
  rst_nopull_a: assert property (pin_pullup[5] == 1'b0) else $error("pin5 pull");
  ext_rst_a: assert property (ext_reset_enable |=> !pin_oe[5]) else $error("pin5 oe");
  osc_free_a: assert property (clock_pins_enable |=> pin_oe[4:3] == 2'b00) else $error("osc oe");
  pull_in_a: assert property ((pin_oe & pin_pullup) == 6'h00) else $error("pull on output");
  data_top_a: assert property (io_read && io_addr == 6'h18 |=> io_rdata[7:5] == 3'b000) else $error("data top");
  sync_lat_a: assert property ($stable(pin_in[1:0])[*4] |->
    {comparator_negative_input, comparator_positive_input} == pin_in[1:0]) else $error("sync");
endmodule
bind sbgp_port sbgp_chk sbgp_chk_inst (.*);

// *** bench/sbgp_pads.sv ***
// Pad model for the six pins
`timescale 1ns/1ps
module sbgp_pads (
  input  wire       clock,
  input  wire [5:0] pin_out,
  input  wire [5:0] pin_oe,
  input  wire [5:0] pin_pullup,
  input  wire [5:0] ext_val,
  input  wire [5:0] ext_en,
  output wire [5:0] pin_in
);
  reg [5:0] flt = 6'h15;
  // A floating pin flips each cycle so a stale read cannot pass
  always @(posedge clock) flt <= ~flt;
  // Own drive wins, then the outside source, then the pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & (pin_pullup | flt));
endmodule

// *** bench/tb.sv ***
// Random and corner-case bench for the six-bit port
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; $display("ERROR %0t %h %h", $time, a, e); end end
module tb;
  logic clock = 1'b0, rstn = 1'b0, io_write = 1'b0, io_read = 1'b0, ext_reset_enable = 1'b0, clock_pins_enable = 1'b0;
  logic [5:0] io_addr = 6'h00, ext_val = 6'h00, ext_en = 6'h00, a, e;
  logic [7:0] io_wdata = 8'h00, r, d, sd = 8'h00, sp = 8'h00;
  logic [31:0] seed = 32'h44;
  wire [7:0] io_rdata;
  wire [5:0] pin_in, pin_out, pin_oe, pin_pullup;
  wire comparator_positive_input, comparator_negative_input, external_interrupt_zero, timer_count_input;
  wire programming_data_in, programming_clock, reset_pin_level, oscillator_input;
  int fail_count = 0, total_checks = 0;
  sbgp_port sbgp_port_inst (.*);
  sbgp_pads sbgp_pads_inst (.*);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Own drive on outputs, outside source on inputs
  function automatic logic [5:0] lvl(input logic [7:0] dr, input logic [7:0] pd, input logic [5:0] ex);
    return (dr[5:0] & pd[5:0]) | (~dr[5:0] & ex);
  endfunction
  // Idle cycle after each access keeps strobes from being set twice at once
  task wr(input logic [5:0] ad, input logic [7:0] v);
    io_addr = ad;
    io_wdata = v;
    io_write = 1'b1;
    @(negedge clock) io_write = 1'b0;
    @(negedge clock);
  endtask
  task rd(input logic [5:0] ad);
    io_addr = ad;
    io_read = 1'b1;
    @(negedge clock) r = io_rdata;
    io_read = 1'b0;
    @(negedge clock);
  endtask
  task tally_and_finish();
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #2 clock = ~clock;
  initial begin
    repeat (12) @(negedge clock);
    rstn = 1'b1;
    rd(6'h17);
    `CHK(r, 8'h00)
    // Writes land on mapped, read-only and unmapped places alike
    repeat (40) begin
      d = rnd();
      a = 6'h16 + rnd() % 4;
      wr(a, d);
      if (a == 6'h17) sd = d & 8'h3f;
      if (a == 6'h18) sp = d & 8'h1f;
      ext_val = rnd();
      ext_en = ~sd[5:0];
      e = lvl(sd, sp, ext_val);
      repeat (4) @(negedge clock);
      rd(6'h18);
      `CHK(r, sp)
      rd(6'h19);
      `CHK(r, sd & 8'h00)
      rd(6'h16);
      `CHK(r, {2'b00, e})
      rd(6'h17);
      `CHK(r, sd)
      `CHK({reset_pin_level, oscillator_input, programming_clock}, {e[5], e[3:2]})
      `CHK(pin_out, {1'b0, sp[4:0]})
      `CHK(pin_pullup, {1'b0, ~sd[4:0] & sp[4:0]})
      `CHK({comparator_positive_input, programming_data_in, comparator_negative_input}, {e[0], e[0], e[1]})
      `CHK({external_interrupt_zero, timer_count_input}, {e[1], e[2]})
    end
    wr(6'h17, 8'h00);
    wr(6'h18, 8'h1f);
    ext_en = 6'h20;
    repeat (4) @(negedge clock);
    rd(6'h16);
    `CHK(r[4:0], 5'h1f)
    clock_pins_enable = 1'b1;
    ext_reset_enable = 1'b1;
    wr(6'h17, 8'h3f);
    `CHK(pin_oe, 6'h07)
    `CHK(pin_out, 6'h07)
    `CHK(pin_pullup, 6'h00)
    clock_pins_enable = 1'b0;
    ext_reset_enable = 1'b0;
    repeat (2) @(negedge clock);
    `CHK(pin_oe, 6'h3f)
    tally_and_finish();
  end
endmodule

// *** design/sbgp_defs.vh ***
// Constants and register layout for the six-bit general-purpose port
`ifndef SBGP_DEFS_VH
`define SBGP_DEFS_VH
`define SBGP_ADDR_PIN_LEVELS   6'h16
`define SBGP_ADDR_DIRECTION    6'h17
`define SBGP_ADDR_OUTPUT_DATA  6'h18
`define SBGP_DATA_MASK         8'h1f
`define SBGP_DIR_MASK_FULL     8'h3f
`define SBGP_DIR_MASK_NO_RST   8'h1f
`define SBGP_PIN_MASK          8'h3f
`define SBGP_RESET_VALUE       8'h00
`define SBGP_BIT_RESET_PIN     5
`define SBGP_BIT_OSC_IN        3
`define SBGP_BIT_OSC_OUT       4
`define SBGP_BIT_PIN_ZERO      0
`define SBGP_BIT_PIN_ONE       1
`define SBGP_BIT_PIN_TWO       2
`define SBGP_CTRL_OUT          2
`define SBGP_CTRL_OE           1
`define SBGP_CTRL_PULL         0
`endif

// *** design/sbgp_port.v ***
// Six-bit general-purpose I/O port with I/O-space registers and pin muxing
`timescale 1ns/1ps
`include "sbgp_defs.vh"
module sbgp_port #(
  parameter RESET_PIN_CAN_OUTPUT = 1
) (
  input  wire       clock,
  input  wire       rstn,
  // I/O-space access from the core
  input  wire [5:0] io_addr,
  input  wire       io_write,
  input  wire       io_read,
  input  wire [7:0] io_wdata,
  output reg  [7:0] io_rdata,
  // Pin function selects
  input  wire       ext_reset_enable,
  input  wire       clock_pins_enable,
  // Pads, four signals per pin
  input  wire [5:0] pin_in,
  output reg  [5:0] pin_out,
  output reg  [5:0] pin_oe,
  output reg  [5:0] pin_pullup,
  // Alternate-function taps
  output reg        comparator_positive_input,
  output reg        comparator_negative_input,
  output reg        external_interrupt_zero,
  output reg        timer_count_input,
  output reg        programming_data_in,
  output reg        programming_clock,
  output reg        reset_pin_level,
  output reg        oscillator_input
);
  localparam [7:0] DIR_MASK = RESET_PIN_CAN_OUTPUT ? `SBGP_DIR_MASK_FULL : `SBGP_DIR_MASK_NO_RST;

  reg  [7:0] port_output_data;
  reg  [7:0] port_direction;
  wire [5:0] pin_levels_sync;
  reg  [5:0] next_out;
  reg  [5:0] next_oe;
  reg  [5:0] next_pullup;
  reg  [7:0] next_rdata;
  wire [7:0] port_pin_levels;

  // Mask a write so fixed-zero bits stay zero
  function [7:0] masked;
    input [7:0] value;
    input [7:0] mask;
    begin
      masked = value & mask;
    end
  endfunction

  // Register select; shared by both write decodes
  function addr_hit;
    input [5:0] addr;
    input [5:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // Pads come from another domain and are synchronised first
  sbgp_sync #(
    .WIDTH (6)
  ) u_sync (
    .clock    (clock),
    .rstn     (rstn),
    .async_in (pin_in),
    .sync_out (pin_levels_sync)
  );

  assign port_pin_levels = masked({2'b00, pin_levels_sync}, `SBGP_PIN_MASK);

  // Register writes; the core does set/clear as read-modify-write of a whole byte,
  // so each byte write only changes the bit the core altered
  always @(posedge clock) begin
    if (!rstn) begin
      port_output_data <= `SBGP_RESET_VALUE;
      port_direction   <= `SBGP_RESET_VALUE;
    end else if (io_write) begin
      if (addr_hit(io_addr, `SBGP_ADDR_OUTPUT_DATA)) begin
        port_output_data <= masked(io_wdata, `SBGP_DATA_MASK);
      end
      if (addr_hit(io_addr, `SBGP_ADDR_DIRECTION)) begin
        port_direction <= masked(io_wdata, DIR_MASK);
      end
    end
  end

  // Read mux; pin-level address is read-only so writes there are dropped
  always @* begin
    next_rdata = 8'h00;
    if (io_read) begin
      case (io_addr)
        `SBGP_ADDR_PIN_LEVELS:  next_rdata = port_pin_levels;
        `SBGP_ADDR_DIRECTION:   next_rdata = port_direction;
        `SBGP_ADDR_OUTPUT_DATA: next_rdata = port_output_data;
        default:                next_rdata = 8'h00;
      endcase
    end
  end

  // Pad control word for one pin: {drive value, enable, pull-up}
  // A pin taken by its alternate function is let go and left unpulled,
  // so a stale register bit can never fight the oscillator
  function [2:0] pad_ctrl;
    input dir_bit;
    input data_bit;
    input taken;
    begin
      if (taken) begin
        pad_ctrl = 3'b000;
      end else begin
        pad_ctrl = {data_bit, dir_bit, ~dir_bit & data_bit};
      end
    end
  endfunction

  reg  [2:0] ctrl_pin_zero;
  reg  [2:0] ctrl_pin_one;
  reg  [2:0] ctrl_pin_two;
  reg  [2:0] ctrl_pin_three;
  reg  [2:0] ctrl_pin_four;
  reg  [2:0] ctrl_reset_pin;
  wire       pin_zero_level;
  wire       pin_one_level;
  wire       pin_two_level;
  wire       pin_three_level;
  wire       pin_five_level;

  // Synchronised level of each pin that feeds a peripheral
  assign pin_zero_level  = pin_levels_sync[`SBGP_BIT_PIN_ZERO];
  assign pin_one_level   = pin_levels_sync[`SBGP_BIT_PIN_ONE];
  assign pin_two_level   = pin_levels_sync[`SBGP_BIT_PIN_TWO];
  assign pin_three_level = pin_levels_sync[`SBGP_BIT_OSC_IN];
  assign pin_five_level  = pin_levels_sync[`SBGP_BIT_RESET_PIN];

  // Lower three pins follow the registers; software sets them for alternates
  always @* begin
    ctrl_pin_zero = pad_ctrl(port_direction[`SBGP_BIT_PIN_ZERO],
                             port_output_data[`SBGP_BIT_PIN_ZERO],
                             1'b0);
    ctrl_pin_one  = pad_ctrl(port_direction[`SBGP_BIT_PIN_ONE],
                             port_output_data[`SBGP_BIT_PIN_ONE],
                             1'b0);
    ctrl_pin_two  = pad_ctrl(port_direction[`SBGP_BIT_PIN_TWO],
                             port_output_data[`SBGP_BIT_PIN_TWO],
                             1'b0);
  end

  // Oscillator pins are plain I/O unless the clock function holds them
  always @* begin
    ctrl_pin_three = pad_ctrl(port_direction[`SBGP_BIT_OSC_IN],
                              port_output_data[`SBGP_BIT_OSC_IN],
                              clock_pins_enable);
    ctrl_pin_four  = pad_ctrl(port_direction[`SBGP_BIT_OSC_OUT],
                              port_output_data[`SBGP_BIT_OSC_OUT],
                              clock_pins_enable);
  end

  // Reset-capable pin: low drive only, steered by its direction bit alone;
  // never pulled up, and let go entirely while it is the external reset
  always @* begin
    ctrl_reset_pin = 3'b000;
    if (RESET_PIN_CAN_OUTPUT != 0 && !ext_reset_enable) begin
      ctrl_reset_pin = {1'b0, port_direction[`SBGP_BIT_RESET_PIN], 1'b0};
    end
  end

  // Gather the per-pin words into the pad vectors
  always @* begin
    next_out    = 6'h00;
    next_oe     = 6'h00;
    next_pullup = 6'h00;
    next_out[`SBGP_BIT_PIN_ZERO]     = ctrl_pin_zero[`SBGP_CTRL_OUT];
    next_out[`SBGP_BIT_PIN_ONE]      = ctrl_pin_one[`SBGP_CTRL_OUT];
    next_out[`SBGP_BIT_PIN_TWO]      = ctrl_pin_two[`SBGP_CTRL_OUT];
    next_out[`SBGP_BIT_OSC_IN]       = ctrl_pin_three[`SBGP_CTRL_OUT];
    next_out[`SBGP_BIT_OSC_OUT]      = ctrl_pin_four[`SBGP_CTRL_OUT];
    next_out[`SBGP_BIT_RESET_PIN]    = ctrl_reset_pin[`SBGP_CTRL_OUT];
    next_oe[`SBGP_BIT_PIN_ZERO]      = ctrl_pin_zero[`SBGP_CTRL_OE];
    next_oe[`SBGP_BIT_PIN_ONE]       = ctrl_pin_one[`SBGP_CTRL_OE];
    next_oe[`SBGP_BIT_PIN_TWO]       = ctrl_pin_two[`SBGP_CTRL_OE];
    next_oe[`SBGP_BIT_OSC_IN]        = ctrl_pin_three[`SBGP_CTRL_OE];
    next_oe[`SBGP_BIT_OSC_OUT]       = ctrl_pin_four[`SBGP_CTRL_OE];
    next_oe[`SBGP_BIT_RESET_PIN]     = ctrl_reset_pin[`SBGP_CTRL_OE];
    next_pullup[`SBGP_BIT_PIN_ZERO]  = ctrl_pin_zero[`SBGP_CTRL_PULL];
    next_pullup[`SBGP_BIT_PIN_ONE]   = ctrl_pin_one[`SBGP_CTRL_PULL];
    next_pullup[`SBGP_BIT_PIN_TWO]   = ctrl_pin_two[`SBGP_CTRL_PULL];
    next_pullup[`SBGP_BIT_OSC_IN]    = ctrl_pin_three[`SBGP_CTRL_PULL];
    next_pullup[`SBGP_BIT_OSC_OUT]   = ctrl_pin_four[`SBGP_CTRL_PULL];
    next_pullup[`SBGP_BIT_RESET_PIN] = ctrl_reset_pin[`SBGP_CTRL_PULL];
  end

  // Read data stands for one cycle after the read strobe,
  // and is zero whenever no read is under way
  always @(posedge clock) begin
    if (!rstn) begin
      io_rdata <= 8'h00;
    end else begin
      io_rdata <= next_rdata;
    end
  end

  // Pad drive value; registered, so pads move two edges after a write
  // and never glitch between two combinational paths
  always @(posedge clock) begin
    if (!rstn) begin
      pin_out <= 6'h00;
    end else begin
      pin_out <= next_out;
    end
  end

  // Pad output enable; released at reset so every pin starts as input,
  // which keeps the board safe until software chooses directions
  always @(posedge clock) begin
    if (!rstn) begin
      pin_oe <= 6'h00;
    end else begin
      pin_oe <= next_oe;
    end
  end

  // Pad pull-up enable; off at reset, switched on only by software
  always @(posedge clock) begin
    if (!rstn) begin
      pin_pullup <= 6'h00;
    end else begin
      pin_pullup <= next_pullup;
    end
  end

  // Comparator positive input sees pin zero
  always @(posedge clock) begin
    if (!rstn) begin
      comparator_positive_input <= 1'b0;
    end else begin
      comparator_positive_input <= pin_zero_level;
    end
  end

  // Programming data input shares pin zero
  always @(posedge clock) begin
    if (!rstn) begin
      programming_data_in <= 1'b0;
    end else begin
      programming_data_in <= pin_zero_level;
    end
  end

  // Comparator negative input sees pin one
  always @(posedge clock) begin
    if (!rstn) begin
      comparator_negative_input <= 1'b0;
    end else begin
      comparator_negative_input <= pin_one_level;
    end
  end

  // External interrupt zero shares pin one; edge detection lives elsewhere
  always @(posedge clock) begin
    if (!rstn) begin
      external_interrupt_zero <= 1'b0;
    end else begin
      external_interrupt_zero <= pin_one_level;
    end
  end

  // Timer count input sees pin two
  always @(posedge clock) begin
    if (!rstn) begin
      timer_count_input <= 1'b0;
    end else begin
      timer_count_input <= pin_two_level;
    end
  end

  // Programming clock shares pin two
  always @(posedge clock) begin
    if (!rstn) begin
      programming_clock <= 1'b0;
    end else begin
      programming_clock <= pin_two_level;
    end
  end

  // Oscillator input level; only a slow copy, not a usable clock
  always @(posedge clock) begin
    if (!rstn) begin
      oscillator_input <= 1'b0;
    end else begin
      oscillator_input <= pin_three_level;
    end
  end

  // Reset pin level for the reset logic when it serves as reset
  always @(posedge clock) begin
    if (!rstn) begin
      reset_pin_level <= 1'b0;
    end else begin
      reset_pin_level <= pin_five_level;
    end
  end
endmodule

// *** design/sbgp_sync.v ***
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
module sbgp_sync #(
  parameter WIDTH = 6
) (
  input  wire             clock,
  input  wire             rstn,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage_one;

  // First stage feeds only the second stage
  always @(posedge clock) begin
    if (!rstn) begin
      stage_one <= {WIDTH{1'b0}};
      sync_out  <= {WIDTH{1'b0}};
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule
